// ---- dv/sfpi_host.sv ----
/* Behavioural host controller on the pins, 160 ns shift clock.
   Assumes clock_i at 10 ns; pins move 1 ns after its rising edge. */
`timescale 1ns/10ps
`default_nettype none
module sfpi_host (
    input  wire logic clock_i,
    input  wire logic serial_out_i,
    output var logic  sclk_o,
    output var logic  select_n_o,
    output var logic  serial_in_o,
    output var logic  pause_n_o
);
    logic m3;
    // Power-up with select already low: no falling edge seen yet
    initial begin
        m3 = 1'b0;
        sclk_o = 1'b0;
        select_n_o = 1'b0;
        serial_in_o = 1'b0;
        pause_n_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Select high first so the device sees a falling edge
    task automatic frame_open(input logic mode3);
        m3 = mode3;
        select_n_o = 1'b1;
        sclk_o = mode3;
        wt(6);
        select_n_o = 1'b0;
        wt(8);
    endtask
    // Idle data flips so a stale level is never mistaken for data
    task automatic frame_close();
        sclk_o = m3;
        wt(8);
        select_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        wt(8);
    endtask
    // Pause at a bit boundary; clock and data thrashed meanwhile
    task automatic pause();
        pause_n_o = 1'b0;
        wt(6);
        repeat (2) begin
            sclk_o = 1'b0;
            serial_in_o = ~serial_in_o;
            wt(6);
            sclk_o = 1'b1;
            wt(6);
        end
        pause_n_o = 1'b1;
        wt(6);
    endtask
    // One byte, MSB first: data set on fall, reply taken on rise
    task automatic xbyte(input logic [7:0] b, input logic pz,
                         output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            if (pz && i == 3) pause();
            sclk_o = 1'b0;
            serial_in_o = b[i];
            wt(8);
            sclk_o = 1'b1;
            r[i] = serial_out_i;
            wt(8);
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/sfpi_top_assertions.sv ----
/* Port checker for sfpi_top, bound at the foot of this file.
   Assumes one clock domain, clock_i, with async reset rst_i. */
`timescale 1ns/10ps
`default_nettype none
module sfpi_top_assertions (
    input wire logic                 clock_i,
    input wire logic                 rst_i,
    input wire logic                 sclk_i,
    input wire logic                 select_n_i,
    input wire logic                 protect_freeze_n_i,
    input wire logic                 serial_out_o,
    input wire logic                 serial_out_oe_o,
    input wire logic                 rx_valid_o,
    input wire sfpi_pkg::sfpi_byte_t rx_byte_o,
    input wire logic                 rx_ready_i,
    input wire logic                 out_phase_i,
    input wire logic                 busy_i,
    input wire logic                 sr_wr_i,
    input wire logic [3:0]           sr_wr_data_i,
    input wire logic                 sr_wr_refused_o,
    input wire logic [2:0]           protect_range_bits_o,
    input wire logic                 status_lock_bit_o,
    input wire logic                 selected_o,
    input wire logic                 active_o,
    input wire logic                 paused_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Status writes once the protect pin has passed the synchroniser
    sequence s_wr_locked;
        !protect_freeze_n_i [*4] ##0 sr_wr_i;
    endsequence
    sequence s_wr_open;
        protect_freeze_n_i [*4] ##0 sr_wr_i;
    endsequence
    AST_OUT_ON_FALL: assert property (serial_out_oe_o && $past(serial_out_oe_o)
        && $changed(serial_out_o) |-> !sclk_i) else $error("out moved, clock high");
    AST_DESEL_HIZ: assert property (select_n_i [*6] |-> !serial_out_oe_o)
        else $error("serial out driven while deselected");
    AST_STANDBY: assert property ((select_n_i && !busy_i) [*6] |-> !active_o)
        else $error("no standby when deselected and idle");
    AST_BUSY_ACTIVE: assert property (busy_i [*2] |-> active_o)
        else $error("standby while internal cycle runs");
    AST_SEL_ACTIVE: assert property (!select_n_i [*6] |-> selected_o && active_o)
        else $error("select low but not active");
    AST_PAUSE_HIZ: assert property (paused_o [*2] |-> !serial_out_oe_o)
        else $error("serial out driven during pause");
    AST_PAUSE_SEL: assert property ($rose(paused_o) |-> selected_o)
        else $error("pause entered while deselected");
    AST_RANGE_FROZEN: assert property (s_wr_locked |-> ##2
        protect_range_bits_o == $past(protect_range_bits_o, 2))
        else $error("range bits changed while frozen");
    AST_LOCK_FROZEN: assert property (s_wr_locked |-> ##[1:2] sr_wr_refused_o
        ##0 status_lock_bit_o == $past(status_lock_bit_o)) else $error("locked write");
    AST_WR_OPEN: assert property (s_wr_open |=>
        {status_lock_bit_o, protect_range_bits_o} == $past(sr_wr_data_i))
        else $error("open status write not stored");
    AST_OE_READ_ONLY: assert property (!out_phase_i [*3] |-> !serial_out_oe_o)
        else $error("serial out driven outside read phase");
    AST_RX_HOLD: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o
        && $stable(rx_byte_o)) else $error("stalled byte not held");
    AST_ROLE: assert property (rx_valid_o |-> $onehot(rx_byte_o.role))
        else $error("byte role not one-hot");
endmodule
bind sfpi_top sfpi_top_assertions u_sfpi_chk (
    .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_i),
    .select_n_i(select_n_i), .protect_freeze_n_i(protect_freeze_n_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .rx_valid_o(rx_valid_o), .rx_byte_o(rx_byte_o), .rx_ready_i(rx_ready_i),
    .out_phase_i(out_phase_i), .busy_i(busy_i), .sr_wr_i(sr_wr_i),
    .sr_wr_data_i(sr_wr_data_i), .sr_wr_refused_o(sr_wr_refused_o),
    .protect_range_bits_o(protect_range_bits_o),
    .status_lock_bit_o(status_lock_bit_o), .selected_o(selected_o),
    .active_o(active_o), .paused_o(paused_o)
);
`default_nettype wire

// ---- dv/sfpi_top_tb.sv ----
/* Self-checking bench of sfpi_top with the host model on its pins.
   Assumes the rtl package and header compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_consts.svh"
module sfpi_top_tb;
    logic                 clock_i, rst_i, sclk, sel_n, sdi, pz_n, prot_n;
    logic                 sdo, sdo_oe, rx_valid, rx_ready, overrun, stall;
    logic                 out_phase, busy, sr_wr, refused, lock, selected;
    logic                 active, seen, free, take;
    logic [2:0]           range;
    logic [3:0]           sr_data, d;
    logic [7:0]           tx_data, last_rd, junk;
    logic [31:0]          seed, rdy_seed;
    sfpi_pkg::sfpi_byte_t rx_byte;
    sfpi_pkg::sfpi_byte_t exp_q[$];
    int                   failures, checked, takes;
    sfpi_top DUT (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
        .select_n_i(sel_n), .serial_in_i(sdi), .pause_n_i(pz_n),
        .protect_freeze_n_i(prot_n), .serial_out_o(sdo),
        .serial_out_oe_o(sdo_oe), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
        .rx_ready_i(rx_ready), .rx_overrun_o(overrun),
        .out_phase_i(out_phase), .tx_data_i(tx_data), .tx_take_o(take),
        .busy_i(busy), .sr_wr_i(sr_wr), .sr_wr_data_i(sr_data),
        .sr_wr_refused_o(refused), .protect_range_bits_o(range),
        .status_lock_bit_o(lock), .selected_o(selected), .active_o(active),
        .paused_o());
    // Undriven line reads as the inverse, so a stray sample shows up
    sfpi_host u_host (.clock_i(clock_i), .serial_out_i(sdo_oe ? sdo : ~sdo),
        .sclk_o(sclk), .select_n_o(sel_n), .serial_in_o(sdi), .pause_n_o(pz_n));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic cmp_rx(input sfpi_pkg::sfpi_byte_t got,
                          input sfpi_pkg::sfpi_byte_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Frame of n random bytes, each noted with its role before sending
    task automatic send_frame(input logic m3, input int n, input int pz_at);
        sfpi_pkg::sfpi_byte_t e;
        logic [7:0]           r;
        u_host.frame_open(m3);
        for (int k = 0; k < n; k++) begin
            seed = lfsr(seed);
            e.data = seed[7:0];
            e.role = (k == 0) ? sfpi_pkg::PH_CMD :
                     (k <= int'(`SFPI_ADDR_BYTES)) ? sfpi_pkg::PH_ADDR :
                     sfpi_pkg::PH_DATA;
            exp_q.push_back(e);
            u_host.xbyte(e.data, k == pz_at, r);
            if (k == 1) last_rd = r;
        end
        u_host.frame_close();
    endtask
    // Bounded wait until every noted byte has come out
    task automatic drain();
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) u_host.wt(1);
        cmp_val(8'(exp_q.size()), 8'h00);
    endtask
    task automatic sr_write(input logic [3:0] v);
        sr_wr = 1'b1;
        sr_data = v;
        u_host.wt(1);
        sr_wr = 1'b0;
        seen = 1'b0;
        repeat (3) begin
            seen = seen | refused;
            u_host.wt(1);
        end
    endtask
    // Clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Random acceptance; random busy and status traffic while free
    always @(posedge clock_i) begin
        #1;
        rdy_seed = lfsr(rdy_seed);
        rx_ready = !stall && rdy_seed[0];
        if (free) begin
            busy = rdy_seed[1];
            sr_wr = rdy_seed[2];
            prot_n = rdy_seed[3];
            sr_data = rdy_seed[7:4];
        end
    end
    // Oldest note compared whenever a byte is handed over
    always @(posedge clock_i) begin
        if (take === 1'b1) takes++;
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) cmp_rx(rx_byte, 'x);
            else cmp_rx(rx_byte, exp_q.pop_front());
        end
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge clock_i);
        failures++;
        wrap_up();
    end
    initial begin
        rst_i = 1'b1;
        prot_n = 1'b1;
        busy = 1'b0;
        sr_wr = 1'b0;
        sr_data = 4'h0;
        out_phase = 1'b0;
        tx_data = 8'h00;
        stall = 1'b0;
        rx_ready = 1'b0;
        free = 1'b0;
        seed = 32'heccd6aec;
        rdy_seed = 32'heccd6aec;
        repeat (16) @(posedge clock_i);
        #1 rst_i = 1'b0;
        free = 1'b1;
        u_host.wt(4);
        u_host.xbyte(8'ha5, 1'b0, junk);
        send_frame(1'b0, 6, -1);
        drain();
        send_frame(1'b1, 5, 2);
        drain();
        // Read phase: byte after the command carries tx_data MSB first
        out_phase = 1'b1;
        seed = lfsr(seed);
        tx_data = seed[15:8];
        send_frame(1'b0, 2, -1);
        out_phase = 1'b0;
        cmp_val(last_rd, tx_data);
        // Byte-boundary falls in read phase: read byte start and frame end
        cmp_val(8'(takes), 8'h02);
        drain();
        cmp_val({7'h0, sdo_oe}, 8'h00);
        // Hard stall: two buffered plus one pending, nothing lost
        stall = 1'b1;
        send_frame(1'b0, 3, -1);
        cmp_val({7'h0, rx_valid}, 8'h01);
        stall = 1'b0;
        drain();
        cmp_val({7'h0, overrun}, 8'h00);
        // Status writes open, then frozen by the protect pin
        free = 1'b0;
        sr_wr = 1'b0;
        busy = 1'b0;
        prot_n = 1'b1;
        u_host.wt(6);
        d = seed[19:16];
        sr_write(d);
        cmp_val({4'h0, lock, range}, {4'h0, d});
        prot_n = 1'b0;
        u_host.wt(6);
        sr_write(~d);
        cmp_val({4'h0, lock, range}, {4'h0, d});
        cmp_val({7'h0, seen}, 8'h01);
        prot_n = 1'b1;
        // Power state against select and internal cycles
        busy = 1'b1;
        u_host.wt(6);
        cmp_val({7'h0, active}, 8'h01);
        busy = 1'b0;
        u_host.wt(6);
        cmp_val({7'h0, active}, 8'h00);
        u_host.frame_open(1'b0);
        cmp_val({6'h0, selected, active}, 8'h03);
        u_host.frame_close();
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- rtl/sfpi_buf.sv ----
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes source and sink on clock_i.
*/
`timescale 1ns/10ps
`default_nettype none

module sfpi_buf (
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic                in_valid_i,
    input  wire sfpi_pkg::sfpi_byte_t in_data_i,
    output logic                     in_ready_o,
    output logic                     out_valid_o,
    output sfpi_pkg::sfpi_byte_t     out_data_o,
    input  wire logic                out_ready_i
);

    sfpi_pkg::sfpi_byte_t head_ff;
    sfpi_pkg::sfpi_byte_t skid_ff;
    logic                 head_vld_ff;
    logic                 skid_vld_ff;
    sfpi_pkg::sfpi_byte_t nxt_head;
    sfpi_pkg::sfpi_byte_t nxt_skid;
    logic                 nxt_head_vld;
    logic                 nxt_skid_vld;
    logic                 push;
    logic                 pop;

    // Head feeds the port; skid fills only while the head waits
    always_comb begin
        push         = in_valid_i && !skid_vld_ff;
        pop          = out_ready_i && head_vld_ff;
        nxt_head     = head_ff;
        nxt_skid     = skid_ff;
        nxt_head_vld = head_vld_ff;
        nxt_skid_vld = skid_vld_ff;
        if (pop || !head_vld_ff) begin
            if (skid_vld_ff) begin
                nxt_head     = skid_ff;
                nxt_skid_vld = 1'h0;
            end else begin
                nxt_head     = in_data_i;
                nxt_head_vld = push;
            end
        end else if (push) begin
            nxt_skid     = in_data_i;
            nxt_skid_vld = 1'h1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            head_ff     <= '0;
            skid_ff     <= '0;
            head_vld_ff <= 1'h0;
            skid_vld_ff <= 1'h0;
        end else begin
            head_ff     <= nxt_head;
            skid_ff     <= nxt_skid;
            head_vld_ff <= nxt_head_vld;
            skid_vld_ff <= nxt_skid_vld;
        end
    end

    // Stream side straight from flops, so the top can pass it out as is
    assign in_ready_o  = !skid_vld_ff;
    assign out_valid_o = head_vld_ff;
    assign out_data_o  = head_ff;

endmodule

`default_nettype wire

// ---- rtl/sfpi_consts.svh ----
/*
 Constants of the serial flash pin front end: counts, field positions
 and reset values. Assumes inclusion by bare name, definitions only.
*/
`ifndef SFPI_CONSTS_SVH
`define SFPI_CONSTS_SVH

// Bits in one byte on the serial line, as last bit index
`define SFPI_LAST_BIT      3'h7
// Address bytes following a command byte
`define SFPI_ADDR_BYTES    2'h3
// Status field positions on the write port
`define SFPI_SR_RANGE_MSB  2
`define SFPI_SR_RANGE_LSB  0
`define SFPI_SR_LOCK_POS   3
// Reset values of the protection state
`define SFPI_RANGE_RST     3'h0
`define SFPI_LOCK_RST      1'h0

`endif

// ---- rtl/sfpi_pkg.sv ----
/*
 Types of the serial flash pin front end.
 Assumes compilation ahead of all sfpi modules.
*/
package sfpi_pkg;

    // Role of a received byte, also the receive phase
    typedef enum logic [2:0] {
        PH_CMD  = 3'b001,
        PH_ADDR = 3'b010,
        PH_DATA = 3'b100
    } sfpi_phase_t;

    // One received byte with its role
    typedef struct packed {
        sfpi_phase_t role;
        logic [7:0]  data;
    } sfpi_byte_t;

endpackage

// ---- rtl/sfpi_sync.sv ----
/*
 Two flip-flop synchroniser for pin levels.
 Assumes inputs asynchronous to clock_i; RST_VAL is the idle pin level.
*/
`timescale 1ns/10ps
`default_nettype none

module sfpi_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // First stage feeds only the second
    always_comb begin
        nxt_meta = d_i;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q_o = q_ff;

endmodule

`default_nettype wire

// ---- rtl/sfpi_top.sv ----
/*
 Pin front end of a serial flash: select, shift clock, serial in/out,
 pause and write-protect pins, received byte stream, transmit bytes and
 the frozen protection state.
 Assumes all pins asynchronous to clock_i and sampled here; the shift
 clock is far slower than clock_i. Decoder logic on clock_i behind it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_consts.svh"

module sfpi_top (
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    // Pins
    input  wire logic                sclk_i,
    input  wire logic                select_n_i,
    input  wire logic                serial_in_i,
    input  wire logic                pause_n_i,
    input  wire logic                protect_freeze_n_i,
    output logic                     serial_out_o,
    output logic                     serial_out_oe_o,
    // Received byte stream
    output logic                     rx_valid_o,
    output sfpi_pkg::sfpi_byte_t     rx_byte_o,
    input  wire logic                rx_ready_i,
    output logic                     rx_overrun_o,
    // Transmit side from the decoder
    input  wire logic                out_phase_i,
    input  wire logic [7:0]          tx_data_i,
    output logic                     tx_take_o,
    // Internal cycle status and status write
    input  wire logic                busy_i,
    input  wire logic                sr_wr_i,
    input  wire logic [3:0]          sr_wr_data_i,
    output logic                     sr_wr_refused_o,
    output logic [2:0]               protect_range_bits_o,
    output logic                     status_lock_bit_o,
    // Power and state
    output logic                     selected_o,
    output logic                     active_o,
    output logic                     paused_o
);

    // Synchronised pins
    logic                 sclk_s;
    logic                 sel_n_s;
    logic                 si_s;
    logic                 pause_n_s;
    logic                 freeze_n_s;

    // Control group
    logic                 sclk_prev_ff;
    logic                 sel_prev_ff;
    logic                 armed_ff;
    logic                 pause_ff;
    logic                 active_ff;
    logic [1:0]           warm_ff;
    logic                 nxt_sclk_prev;
    logic                 nxt_sel_prev;
    logic                 nxt_armed;
    logic                 nxt_pause;
    logic                 nxt_active;
    logic [1:0]           nxt_warm;

    // Receive group
    logic [2:0]           bit_cnt_ff;
    logic [6:0]           shreg_ff;
    sfpi_pkg::sfpi_phase_t phase_ff;
    logic [1:0]           addr_cnt_ff;
    sfpi_pkg::sfpi_byte_t pend_ff;
    logic                 pend_vld_ff;
    logic                 overrun_ff;
    logic [2:0]           nxt_bit_cnt;
    logic [6:0]           nxt_shreg;
    sfpi_pkg::sfpi_phase_t nxt_phase;
    logic [1:0]           nxt_addr_cnt;
    sfpi_pkg::sfpi_byte_t nxt_pend;
    logic                 nxt_pend_vld;
    logic                 nxt_overrun;

    // Transmit group
    logic [6:0]           tx_sh_ff;
    logic                 so_ff;
    logic                 so_oe_ff;
    logic                 tx_take_ff;
    logic [6:0]           nxt_tx_sh;
    logic                 nxt_so;
    logic                 nxt_so_oe;
    logic                 nxt_tx_take;

    // Protection group
    logic [2:0]           range_ff;
    logic                 lock_ff;
    logic                 refused_ff;
    logic [2:0]           nxt_range;
    logic                 nxt_lock;
    logic                 nxt_refused;

    // Buffer input handshake
    logic                 buf_in_ready;

    // Decoded conditions
    logic                 selected;
    logic                 go;
    logic                 rise;
    logic                 fall;
    logic                 sel_fall;
    logic                 byte_done;

    // One edge finder for clock and select
    function automatic logic edge_of(input logic prev,
                                     input logic now,
                                     input logic to_high);
        edge_of = to_high ? (now && !prev) : (!now && prev);
    endfunction

    // Idle levels: select high, pause and protect inactive
    sfpi_sync #(.W(5), .RST_VAL(5'h0e)) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     ({sclk_i, select_n_i, pause_n_i, protect_freeze_n_i,
                   serial_in_i}),
        .q_o     ({sclk_s, sel_n_s, pause_n_s, freeze_n_s, si_s})
    );

    // Edges work for either idle clock level, so modes 0 and 3 agree
    always_comb begin
        selected  = !sel_n_s;
        rise      = edge_of(sclk_prev_ff, sclk_s, 1'h1);
        fall      = edge_of(sclk_prev_ff, sclk_s, 1'h0);
        sel_fall  = edge_of(sel_prev_ff, selected, 1'h1);
        go        = selected && armed_ff && !pause_ff;
        byte_done = go && rise && (bit_cnt_ff == `SFPI_LAST_BIT);
    end

    // Arming, pause, power; a select held low through reset never arms
    always_comb begin
        nxt_sclk_prev = sclk_s;
        nxt_sel_prev  = selected;
        nxt_warm      = warm_ff + {1'h0, warm_ff != 2'h3};
        nxt_armed     = armed_ff || (sel_fall && warm_ff == 2'h3);
        nxt_pause     = pause_ff;
        if (!selected) begin
            nxt_pause = 1'h0;
        end else if (!pause_n_s) begin
            nxt_pause = 1'h1;
        end else begin
            nxt_pause = 1'h0;
        end
        // Pause only gates the pins; busy_i runs on untouched
        nxt_active = selected || busy_i;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev_ff <= 1'h0;
            sel_prev_ff  <= 1'h0;
            warm_ff      <= 2'h0;
            armed_ff     <= 1'h0;
            pause_ff     <= 1'h0;
            active_ff    <= 1'h0;
        end else begin
            sclk_prev_ff <= nxt_sclk_prev;
            sel_prev_ff  <= nxt_sel_prev;
            warm_ff      <= nxt_warm;
            armed_ff     <= nxt_armed;
            pause_ff     <= nxt_pause;
            active_ff    <= nxt_active;
        end
    end

    // Byte assembly and role tagging; deselect restarts at a command
    always_comb begin
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shreg    = shreg_ff;
        nxt_phase    = phase_ff;
        nxt_addr_cnt = addr_cnt_ff;
        nxt_pend     = pend_ff;
        nxt_pend_vld = pend_vld_ff && !buf_in_ready;
        nxt_overrun  = overrun_ff;
        if (!selected) begin
            nxt_bit_cnt  = 3'h0;
            nxt_phase    = sfpi_pkg::PH_CMD;
            nxt_addr_cnt = 2'h0;
        end else if (go && rise) begin
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            nxt_shreg   = {shreg_ff[5:0], si_s};
            if (byte_done) begin
                nxt_pend.role = phase_ff;
                nxt_pend.data = {shreg_ff, si_s};
                nxt_pend_vld  = 1'h1;
                if (pend_vld_ff && !buf_in_ready) begin
                    nxt_overrun = 1'h1;
                end
                case (phase_ff)
                    sfpi_pkg::PH_CMD: begin
                        nxt_phase    = sfpi_pkg::PH_ADDR;
                        nxt_addr_cnt = 2'h0;
                    end
                    sfpi_pkg::PH_ADDR: begin
                        nxt_addr_cnt = addr_cnt_ff + 2'h1;
                        if (addr_cnt_ff == `SFPI_ADDR_BYTES - 2'h1) begin
                            nxt_phase = sfpi_pkg::PH_DATA;
                        end
                    end
                    sfpi_pkg::PH_DATA: begin
                        nxt_phase = sfpi_pkg::PH_DATA;
                    end
                    default: begin
                        nxt_phase = sfpi_pkg::PH_CMD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_ff  <= 3'h0;
            shreg_ff    <= 7'h00;
            phase_ff    <= sfpi_pkg::PH_CMD;
            addr_cnt_ff <= 2'h0;
            pend_ff     <= '0;
            pend_vld_ff <= 1'h0;
            overrun_ff  <= 1'h0;
        end else begin
            bit_cnt_ff  <= nxt_bit_cnt;
            shreg_ff    <= nxt_shreg;
            phase_ff    <= nxt_phase;
            addr_cnt_ff <= nxt_addr_cnt;
            pend_ff     <= nxt_pend;
            pend_vld_ff <= nxt_pend_vld;
            overrun_ff  <= nxt_overrun;
        end
    end

    // Two entries absorb a short decoder stall without loss
    sfpi_buf u_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (pend_vld_ff),
        .in_data_i   (pend_ff),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (rx_valid_o),
        .out_data_o  (rx_byte_o),
        .out_ready_i (rx_ready_i)
    );

    // Serial output; a new byte is taken at each read-phase fall on a byte boundary
    always_comb begin
        nxt_tx_sh   = tx_sh_ff;
        nxt_so      = so_ff;
        nxt_tx_take = 1'h0;
        nxt_so_oe   = go && out_phase_i;
        if (go && fall && out_phase_i) begin
            if (bit_cnt_ff == 3'h0) begin
                nxt_so      = tx_data_i[7];
                nxt_tx_sh   = tx_data_i[6:0];
                nxt_tx_take = 1'h1;
            end else begin
                nxt_so    = tx_sh_ff[6];
                nxt_tx_sh = {tx_sh_ff[5:0], 1'h0};
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_ff   <= 7'h00;
            so_ff      <= 1'h0;
            so_oe_ff   <= 1'h0;
            tx_take_ff <= 1'h0;
        end else begin
            tx_sh_ff   <= nxt_tx_sh;
            so_ff      <= nxt_so;
            so_oe_ff   <= nxt_so_oe;
            tx_take_ff <= nxt_tx_take;
        end
    end

    // Protection bits; a frozen write is refused, not queued
    always_comb begin
        nxt_range   = range_ff;
        nxt_lock    = lock_ff;
        nxt_refused = 1'h0;
        if (sr_wr_i) begin
            if (!freeze_n_s) begin
                nxt_refused = 1'h1;
            end else begin
                nxt_range = sr_wr_data_i[`SFPI_SR_RANGE_MSB:
                                         `SFPI_SR_RANGE_LSB];
                nxt_lock  = sr_wr_data_i[`SFPI_SR_LOCK_POS];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            range_ff   <= `SFPI_RANGE_RST;
            lock_ff    <= `SFPI_LOCK_RST;
            refused_ff <= 1'h0;
        end else begin
            range_ff   <= nxt_range;
            lock_ff    <= nxt_lock;
            refused_ff <= nxt_refused;
        end
    end

    // Ports from flops; rx stream comes from the buffer's head flops
    assign serial_out_o         = so_ff;
    assign serial_out_oe_o      = so_oe_ff;
    assign rx_overrun_o         = overrun_ff;
    assign tx_take_o            = tx_take_ff;
    assign sr_wr_refused_o      = refused_ff;
    assign protect_range_bits_o = range_ff;
    assign status_lock_bit_o    = lock_ff;
    assign selected_o           = sel_prev_ff;
    assign active_o             = active_ff;
    assign paused_o             = pause_ff;

endmodule

`default_nettype wire
